//--- tlbws_top.sv
// Instruction and data translation buffers: storage, reset contents,
// maintenance writes, hardware refill writes and a registered lookup.
// Assumes the pipeline issues at most one write and one lookup per cycle.
`timescale 1ns/1ps

// Notes on behaviour
// - Instruction buffer has seven ways, 0-6.
// - Ways 0-3 hold 4 kB refilled pages.
// - Refill ways total 16 or 32 entries.
// - Way 4: four entries, configurable large size.
// - Reset clears identifiers except fixed ways 5/6 and variable way 6.
// - Fixed way 5: cached and bypass kernel map.
// - Constant entries carry identifier one.
// - Variable way 5: four 128/256 MB entries.
// - Fixed way 6: top 512 MB two maps.
// - Variable way 6 resets to flat bypass.
// - Data buffer adds single-entry ways 7-9.
// - Refill never replaces data ways 7-9.
// - Writes to fixed ways 5/6 change nothing.
// - Address operand: way low, page number high.
// - Ring selects stored identifier; attribute low.
// - Data operand holds physical page high.
// - Fixed ways keep constants, match ring 0.
// - Ring identifiers reset 04030201, ring0 fixed.
// - Way 4 size field bits 17:16.
module tlbws_top import tlbws_pkg::*; #(
  parameter int INST_REFILL_ENTRY_COUNT  = 16,
  parameter int DATA_REFILL_ENTRY_COUNT  = 16,
  parameter bit INST_LARGE_WAYS_VARIABLE = 1'b0,
  parameter bit DATA_LARGE_WAYS_VARIABLE = 1'b0
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_inst_cfg_we,
  input  wire logic        i_data_cfg_we,
  input  wire logic        i_ring_ids_we,
  input  wire logic [31:0] i_sr_wdata,
  output logic      [31:0] o_inst_page_size_config,
  output logic      [31:0] o_data_page_size_config,
  output logic      [31:0] o_per_ring_space_ids,
  input  wire logic        i_wr_valid,
  input  wire logic        i_wr_sel,
  input  wire logic [31:0] i_wr_as,
  input  wire logic [31:0] i_wr_at,
  input  wire logic        i_refill_valid,
  input  wire logic        i_refill_sel,
  input  wire logic [31:0] i_refill_vaddr,
  input  wire logic [31:0] i_refill_pte,
  output logic             o_refill_ready,
  input  wire logic        i_lk_valid,
  input  wire logic        i_lk_sel,
  input  wire logic [31:0] i_lk_vaddr,
  input  wire logic [1:0]  i_lk_ring,
  output logic             o_lk_done,
  output logic             o_lk_hit,
  output logic             o_lk_miss,
  output logic             o_lk_multi,
  output logic      [31:0] o_lk_paddr,
  output logic      [3:0]  o_lk_attr
);
  // ************************************************************
  // Build-time view per buffer
  // ************************************************************
  function automatic logic fn_var(input logic sel);
    fn_var = sel ? DATA_LARGE_WAYS_VARIABLE : INST_LARGE_WAYS_VARIABLE;
  endfunction

  function automatic logic [3:0] fn_nways(input logic sel);
    fn_nways = sel ? 4'(NUM_WAY_DATA) : 4'(NUM_WAY_INST);
  endfunction

  // Page offset width of a way, from its configuration
  function automatic logic [4:0] fn_shift(input logic [3:0] w,
                                          input logic [31:0] cfg,
                                          input logic vw);
    logic [4:0] sh;
    sh = 5'(PAGE_SHIFT);
    if (w == WAY_LARGE) begin
      sh = SH_W4_BASE + {2'b00, cfg[CFG_W4_LSB+1:CFG_W4_LSB], 1'b0};
    end else if (w == WAY_5) begin
      sh = (vw && cfg[CFG_W5_BIT]) ? SH_256M : SH_128M;
    end else if (w == WAY_6) begin
      sh = vw ? (cfg[CFG_W6_BIT] ? SH_256M : SH_512M) : SH_256M;
    end
    fn_shift = sh;
  endfunction

  // Number of index bits of a way
  function automatic logic [1:0] fn_nbits(input logic [3:0] w,
                                          input logic vw,
                                          input logic big_refill);
    logic [1:0] nb;
    nb = 2'd0;
    if (w < 4'(REFILL_WAYS)) begin
      nb = big_refill ? 2'd3 : 2'd2;
    end else if (w == WAY_LARGE) begin
      nb = 2'd2;
    end else if (w == WAY_5) begin
      nb = vw ? 2'd2 : 2'd1;
    end else if (w == WAY_6) begin
      nb = vw ? 2'd3 : 2'd1;
    end
    fn_nbits = nb;
  endfunction

  function automatic logic [2:0] fn_index(input logic [31:0] va,
                                          input logic [4:0] sh,
                                          input logic [1:0] nb);
    logic [31:0] t;
    t = va >> sh;
    unique case (nb)
      2'd0: fn_index = 3'd0;
      2'd1: fn_index = {2'b00, t[0]};
      2'd2: fn_index = {1'b0, t[1:0]};
      2'd3: fn_index = t[2:0];
    endcase
  endfunction

  // ************************************************************
  // Configuration and ring identifier registers
  // ************************************************************
  logic [31:0] inst_cfg_r, inst_cfg_nxt;
  logic [31:0] data_cfg_r, data_cfg_nxt;
  logic [31:0] ring_ids_r, ring_ids_nxt;

  always_comb begin
    inst_cfg_nxt = i_inst_cfg_we ? (i_sr_wdata & CFG_MASK) : inst_cfg_r;
    data_cfg_nxt = i_data_cfg_we ? (i_sr_wdata & CFG_MASK) : data_cfg_r;
    ring_ids_nxt = ring_ids_r;
    if (i_ring_ids_we) begin
      ring_ids_nxt = {i_sr_wdata[31:8], ASID_RING0};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      inst_cfg_r <= CFG_RST;
      data_cfg_r <= CFG_RST;
      ring_ids_r <= RING_IDS_RST;
    end else begin
      inst_cfg_r <= inst_cfg_nxt;
      data_cfg_r <= data_cfg_nxt;
      ring_ids_r <= ring_ids_nxt;
    end
  end

  assign o_inst_page_size_config = inst_cfg_r;
  assign o_data_page_size_config = data_cfg_r;
  assign o_per_ring_space_ids    = ring_ids_r;

  // ************************************************************
  // Write path: maintenance has priority over refill
  // ************************************************************
  logic [1:0]  rr_r, rr_nxt;
  logic        refill_acc;
  logic        wr_en, wr_sel;
  logic [3:0]  wr_way;
  logic [2:0]  wr_idx;
  logic [31:0] wr_va, wr_dat, wr_cfg;
  logic [19:0] wr_vpn, wr_ppn;
  logic [7:0]  wr_asid;
  logic [3:0]  wr_attr;

  assign o_refill_ready = !i_wr_valid;
  assign refill_acc     = i_refill_valid && !i_wr_valid;

  always_comb begin
    wr_sel = i_wr_valid ? i_wr_sel : i_refill_sel;
    wr_va  = i_wr_valid ? i_wr_as : i_refill_vaddr;
    wr_dat = i_wr_valid ? i_wr_at : i_refill_pte;
    // Refill picks a way round robin, only among ways 0-3
    wr_way = i_wr_valid ? i_wr_as[WAY_LSB+3:WAY_LSB] : {2'b00, rr_r};
    wr_cfg = wr_sel ? data_cfg_r : inst_cfg_r;
    wr_en  = i_wr_valid || refill_acc;
    // Ways past the end of a buffer are simply dropped
    if (wr_way >= fn_nways(wr_sel)) begin
      wr_en = 1'b0;
    end
    if ((wr_way == WAY_5 || wr_way == WAY_6) && !fn_var(wr_sel)) begin
      wr_en = 1'b0;
    end
    wr_idx = fn_index(wr_va, fn_shift(wr_way, wr_cfg, fn_var(wr_sel)),
                      fn_nbits(wr_way, fn_var(wr_sel),
                               (wr_sel ? DATA_REFILL_ENTRY_COUNT
                                       : INST_REFILL_ENTRY_COUNT)
                               == REFILL_ENT_32));
    // Unused low page bits are kept; lookup masks them by page size
    wr_vpn  = wr_va[31:PN_LSB];
    wr_ppn  = wr_dat[31:PN_LSB];
    wr_attr = wr_dat[ATTR_LSB+3:ATTR_LSB];
    wr_asid = ring_ids_r[8*wr_dat[RING_LSB+1:RING_LSB] +: 8];
    rr_nxt  = refill_acc ? rr_r + 2'd1 : rr_r;
  end

  // ************************************************************
  // Entry storage, both buffers, with reset contents
  // ************************************************************
  logic [19:0] ent_vpn_r  [NUM_SEL][MAX_WAY][MAX_ENTRY];
  logic [19:0] ent_ppn_r  [NUM_SEL][MAX_WAY][MAX_ENTRY];
  logic [7:0]  ent_asid_r [NUM_SEL][MAX_WAY][MAX_ENTRY];
  logic [3:0]  ent_attr_r [NUM_SEL][MAX_WAY][MAX_ENTRY];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rr_r <= 2'd0;
      for (int s = 0; s < NUM_SEL; s++) begin
        for (int w = 0; w < MAX_WAY; w++) begin
          for (int e = 0; e < MAX_ENTRY; e++) begin
            ent_vpn_r[s][w][e]  <= 20'h00000;
            ent_ppn_r[s][w][e]  <= 20'h00000;
            ent_asid_r[s][w][e] <= ASID_INVALID;
            ent_attr_r[s][w][e] <= 4'h0;
          end
        end
        if (!fn_var(s[0])) begin
          ent_vpn_r[s][5][0]  <= W5_VPN_CACHE;
          ent_vpn_r[s][5][1]  <= W5_VPN_BYP;
          ent_ppn_r[s][5][0]  <= W5_PPN;
          ent_ppn_r[s][5][1]  <= W5_PPN;
          ent_attr_r[s][5][0] <= ATTR_CACHED;
          ent_attr_r[s][5][1] <= ATTR_BYP_FIX;
          ent_vpn_r[s][6][0]  <= W6_VPN_CACHE;
          ent_vpn_r[s][6][1]  <= W6_VPN_BYP;
          ent_ppn_r[s][6][0]  <= W6_PPN;
          ent_ppn_r[s][6][1]  <= W6_PPN;
          ent_attr_r[s][6][0] <= ATTR_CACHED;
          ent_attr_r[s][6][1] <= ATTR_BYP_FIX;
          for (int e = 0; e < 2; e++) begin
            ent_asid_r[s][5][e] <= ASID_RING0;
            ent_asid_r[s][6][e] <= ASID_RING0;
          end
        end else begin
          // Flat bypass map of all memory in 512 MB pages
          for (int e = 0; e < MAX_ENTRY; e++) begin
            ent_vpn_r[s][6][e]  <= {3'(e), 17'h00000};
            ent_ppn_r[s][6][e]  <= {3'(e), 17'h00000};
            ent_asid_r[s][6][e] <= ASID_RING0;
            ent_attr_r[s][6][e] <= ATTR_BYP_VAR;
          end
        end
      end
    end else begin
      rr_r <= rr_nxt;
      if (wr_en) begin
        ent_vpn_r[wr_sel][wr_way][wr_idx]  <= wr_vpn;
        ent_ppn_r[wr_sel][wr_way][wr_idx]  <= wr_ppn;
        ent_asid_r[wr_sel][wr_way][wr_idx] <= wr_asid;
        ent_attr_r[wr_sel][wr_way][wr_idx] <= wr_attr;
      end
    end
  end

  // ************************************************************
  // Lookup, answered one cycle later
  // ************************************************************
  logic        lk_hit, lk_multi;
  logic [31:0] lk_paddr;
  logic [3:0]  lk_attr;
  logic        done_r, hit_r, multi_r;
  logic [31:0] paddr_r;
  logic [3:0]  attr_r;

  always_comb begin
    logic [31:0] cfg;
    logic [4:0]  sh;
    logic [1:0]  nb;
    logic [19:0] msk;
    logic        ok;
    cfg      = i_lk_sel ? data_cfg_r : inst_cfg_r;
    sh       = 5'(PAGE_SHIFT);
    nb       = 2'd0;
    msk      = 20'hfffff;
    ok       = 1'b0;
    lk_hit   = 1'b0;
    lk_multi = 1'b0;
    lk_paddr = 32'h0000_0000;
    lk_attr  = 4'h0;
    for (int w = 0; w < MAX_WAY; w++) begin
      sh  = fn_shift(4'(w), cfg, fn_var(i_lk_sel));
      nb  = fn_nbits(4'(w), fn_var(i_lk_sel),
                     (i_lk_sel ? DATA_REFILL_ENTRY_COUNT
                               : INST_REFILL_ENTRY_COUNT) == REFILL_ENT_32);
      msk = 20'hfffff << (sh - 5'(PAGE_SHIFT));
      for (int e = 0; e < MAX_ENTRY; e++) begin
        ok = 1'b0;
        for (int r = 0; r < 4; r++) begin
          if (2'(r) <= i_lk_ring && ent_asid_r[i_lk_sel][w][e] != 8'h00 &&
              ent_asid_r[i_lk_sel][w][e] == ring_ids_r[8*r +: 8]) begin
            ok = 1'b1;
          end
        end
        if (4'(w) < fn_nways(i_lk_sel) && (e < (1 << nb)) && ok &&
            ((ent_vpn_r[i_lk_sel][w][e] ^ i_lk_vaddr[31:PN_LSB]) & msk)
            == 20'h00000) begin
          lk_multi = lk_multi | lk_hit;
          lk_hit   = 1'b1;
          lk_paddr = {(ent_ppn_r[i_lk_sel][w][e] & msk) |
                      (i_lk_vaddr[31:PN_LSB] & ~msk),
                      i_lk_vaddr[PN_LSB-1:0]};
          lk_attr  = ent_attr_r[i_lk_sel][w][e];
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      done_r  <= 1'b0;
      hit_r   <= 1'b0;
      multi_r <= 1'b0;
      paddr_r <= 32'h0000_0000;
      attr_r  <= 4'h0;
    end else begin
      done_r  <= i_lk_valid;
      hit_r   <= i_lk_valid && lk_hit;
      multi_r <= i_lk_valid && lk_multi;
      paddr_r <= lk_paddr;
      attr_r  <= lk_attr;
    end
  end

  assign o_lk_done  = done_r;
  assign o_lk_hit   = hit_r;
  assign o_lk_miss  = done_r && !hit_r;
  assign o_lk_multi = multi_r;
  assign o_lk_paddr = paddr_r;
  assign o_lk_attr  = attr_r;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic [2:0] chk_idx_r;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) chk_idx_r <= 3'd0;
    else chk_idx_r <= wr_idx;
  end

  a_lk_latency: assert property (o_lk_done == $past(i_lk_valid))
    else $error("lookup answer late");
  a_ring0_fixed: assert property (o_per_ring_space_ids[7:0] == 8'h01)
    else $error("ring 0 identifier not one");
  a_reset_ids: assert property ($past(i_rst) |->
      ent_asid_r[0][0][0] == 8'h00 && ent_asid_r[1][9][0] == 8'h00 &&
      ent_asid_r[1][4][3] == 8'h00)
    else $error("identifier not cleared by reset");
  a_fixed_way5: assert property (!INST_LARGE_WAYS_VARIABLE |->
      ent_attr_r[0][5][0] == 4'h7 && ent_attr_r[0][5][1] == 4'h3 &&
      ent_asid_r[0][5][1] == 8'h01) else $error("way 5 constant lost");
  a_fixed_way6: assert property (!DATA_LARGE_WAYS_VARIABLE |->
      ent_ppn_r[1][6][0] == 20'hf0000 && ent_asid_r[1][6][0] == 8'h01)
    else $error("way 6 constant lost");
  a_fixed_write: assert property (i_wr_valid && !i_wr_sel &&
      i_wr_as[3:0] == 4'h5 && !INST_LARGE_WAYS_VARIABLE |=>
      $stable(ent_ppn_r[0][5][0]) && $stable(ent_vpn_r[0][5][1]))
    else $error("fixed way written");
  a_refill_protect: assert property (refill_acc && i_refill_sel |=>
      $stable(ent_vpn_r[1][7][0]) && $stable(ent_vpn_r[1][9][0]))
    else $error("refill touched way 7-9");
  a_write_ring0: assert property (i_wr_valid && !i_wr_sel &&
      i_wr_as[3:0] == 4'h0 && i_wr_at[5:4] == 2'b00 |=>
      ent_asid_r[0][0][chk_idx_r] == 8'h01)
    else $error("ring 0 write stored wrong identifier");

  c_refill: cover property (refill_acc ##1 i_lk_valid ##1 o_lk_hit);
  c_miss: cover property (o_lk_miss);
  c_multi: cover property (o_lk_multi);
  c_wr_clash: cover property (i_wr_valid && i_refill_valid);
endmodule

//--- tlbws_pkg.sv
// Constants shared by the translation buffer pair: layouts, reset values.
// Assumes a single core clock and an active-high asynchronous core reset.
package tlbws_pkg;
  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int NUM_SEL       = 2;
  localparam int NUM_WAY_INST  = 7;
  localparam int NUM_WAY_DATA  = 10;
  localparam int MAX_WAY       = 10;
  localparam int MAX_ENTRY     = 8;
  localparam int REFILL_WAYS   = 4;
  localparam int REFILL_ENT_32 = 32;
  localparam int VPN_W         = 20;
  localparam int ASID_W        = 8;
  localparam int ATTR_W        = 4;
  localparam int PAGE_SHIFT    = 12;
  localparam logic [3:0] WAY_LARGE = 4'h4;
  localparam logic [3:0] WAY_5     = 4'h5;
  localparam logic [3:0] WAY_6     = 4'h6;
  // ************************************************************
  // Operand fields
  // ************************************************************
  localparam int WAY_LSB  = 0;
  localparam int ATTR_LSB = 0;
  localparam int RING_LSB = 4;
  localparam int PN_LSB   = 12;
  // ************************************************************
  // Page size configuration fields and shifts
  // ************************************************************
  localparam int CFG_W4_LSB = 16;
  localparam int CFG_W5_BIT = 20;
  localparam int CFG_W6_BIT = 24;
  localparam logic [31:0] CFG_MASK  = 32'h0113_0000;
  localparam logic [31:0] CFG_RST   = 32'h0000_0000;
  localparam logic [4:0] SH_W4_BASE = 5'd20;
  localparam logic [4:0] SH_128M    = 5'd27;
  localparam logic [4:0] SH_256M    = 5'd28;
  localparam logic [4:0] SH_512M    = 5'd29;
  // ************************************************************
  // Reset and constant contents
  // ************************************************************
  localparam logic [31:0] RING_IDS_RST = 32'h0403_0201;
  localparam logic [7:0]  ASID_RING0   = 8'h01;
  localparam logic [7:0]  ASID_INVALID = 8'h00;
  localparam logic [3:0]  ATTR_CACHED  = 4'h7;
  localparam logic [3:0]  ATTR_BYP_FIX = 4'h3;
  localparam logic [3:0]  ATTR_BYP_VAR = 4'h2;
  localparam logic [19:0] W5_VPN_CACHE = 20'hd0000;
  localparam logic [19:0] W5_VPN_BYP   = 20'hd8000;
  localparam logic [19:0] W5_PPN       = 20'h00000;
  localparam logic [19:0] W6_VPN_CACHE = 20'he0000;
  localparam logic [19:0] W6_VPN_BYP   = 20'hf0000;
  localparam logic [19:0] W6_PPN       = 20'hf0000;
endpackage

//--- tlbws_refill_model.sv
// Far-side model: the pipeline's refill request source.
// Assumes ready is sampled on the rising edge of the core clock.
`timescale 1ns/1ps
module tlbws_refill_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_go,
  input  wire logic        i_sel,
  input  wire logic [31:0] i_vaddr,
  input  wire logic [31:0] i_pte,
  input  wire logic        i_ready,
  output logic             o_valid,
  output logic             o_sel,
  output logic      [31:0] o_vaddr,
  output logic      [31:0] o_pte
);
  // ************************************************************
  // Request held until accepted
  // ************************************************************
  // Released lines show the inverse so stale values never look valid
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_sel   <= 1'b0;
      o_vaddr <= 32'h0;
      o_pte   <= 32'h0;
    end else if (o_valid && i_ready) begin
      o_valid <= 1'b0;
      o_sel   <= ~o_sel;
      o_vaddr <= ~o_vaddr;
      o_pte   <= ~o_pte;
    end else if (i_go && !o_valid) begin
      o_valid <= 1'b1;
      o_sel   <= i_sel;
      o_vaddr <= i_vaddr;
      o_pte   <= {i_pte[31:12], 6'h00, i_pte[5:0]};
    end
  end
endmodule

//--- tb_top.sv
// Self-checking bench for the translation buffer pair.
// Assumes default parameters: 16 refill entries, fixed ways 5 and 6.
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        icfg_we = 1'b0;
  logic        dcfg_we = 1'b0;
  logic        ids_we = 1'b0;
  logic [31:0] sr_wdata = 32'h0;
  logic [31:0] icfg;
  logic [31:0] dcfg;
  logic [31:0] ids;
  logic        wr_valid = 1'b0;
  logic        wr_sel = 1'b0;
  logic [31:0] wr_as = 32'h0;
  logic [31:0] wr_at = 32'h0;
  logic        go = 1'b0;
  logic        rf_valid;
  logic        rf_sel;
  logic [31:0] rf_vaddr;
  logic [31:0] rf_pte;
  logic        rf_ready;
  logic        rf_in_sel = 1'b0;
  logic [31:0] rf_in_va = 32'h00005678;
  logic [31:0] rf_in_pte = 32'hbcdef013;
  logic        lk_valid = 1'b0;
  logic        lk_sel = 1'b0;
  logic [31:0] lk_vaddr = 32'h0;
  logic [1:0]  lk_ring = 2'h0;
  logic        done;
  logic        hit;
  logic        miss;
  logic        multi;
  logic        exp_multi = 1'b0;
  logic [31:0] paddr;
  logic [3:0]  attr;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [31:0] va_t [4] = '{32'hd0000123, 32'hd8000123, 32'he0000123,
                            32'hf0000123};
  logic [31:0] pa_t [4] = '{32'h00000123, 32'h00000123, 32'hf0000123,
                            32'hf0000123};
  logic [3:0]  at_t [4] = '{4'h7, 4'h3, 4'h7, 4'h3};

  always #5 clk = ~clk;

  tlbws_top #(
    .INST_REFILL_ENTRY_COUNT  (16),
    .DATA_REFILL_ENTRY_COUNT  (16),
    .INST_LARGE_WAYS_VARIABLE (1'b0),
    .DATA_LARGE_WAYS_VARIABLE (1'b0)
  ) dut_u (
    .i_clk(clk), .i_rst(rst), .i_inst_cfg_we(icfg_we),
    .i_data_cfg_we(dcfg_we), .i_ring_ids_we(ids_we),
    .i_sr_wdata(sr_wdata), .o_inst_page_size_config(icfg),
    .o_data_page_size_config(dcfg), .o_per_ring_space_ids(ids),
    .i_wr_valid(wr_valid), .i_wr_sel(wr_sel), .i_wr_as(wr_as),
    .i_wr_at(wr_at), .i_refill_valid(rf_valid), .i_refill_sel(rf_sel),
    .i_refill_vaddr(rf_vaddr), .i_refill_pte(rf_pte),
    .o_refill_ready(rf_ready), .i_lk_valid(lk_valid), .i_lk_sel(lk_sel),
    .i_lk_vaddr(lk_vaddr), .i_lk_ring(lk_ring), .o_lk_done(done),
    .o_lk_hit(hit), .o_lk_miss(miss), .o_lk_multi(multi),
    .o_lk_paddr(paddr), .o_lk_attr(attr)
  );

  tlbws_refill_model model_u (
    .i_clk(clk), .i_rst(rst), .i_go(go), .i_sel(rf_in_sel),
    .i_vaddr(rf_in_va), .i_pte(rf_in_pte), .i_ready(rf_ready),
    .o_valid(rf_valid), .o_sel(rf_sel), .o_vaddr(rf_vaddr),
    .o_pte(rf_pte)
  );

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sreg(input int k, input logic [31:0] d);
    @(negedge clk);
    icfg_we = (k == 0);
    dcfg_we = (k == 1);
    ids_we = (k == 2);
    sr_wdata = d;
    @(negedge clk);
    {icfg_we, dcfg_we, ids_we} = 3'h0;
  endtask

  task automatic wr(input logic s, input logic [31:0] a, input logic [31:0] t);
    @(negedge clk);
    wr_valid = 1'b1;
    wr_sel = s;
    wr_as = a; // Callers keep to ways that exist
    wr_at = t;
    @(negedge clk);
    wr_valid = 1'b0;
  endtask

  // Answer is fixed at one cycle, so no wait loop is needed
  task automatic lk(input logic s, input logic [31:0] va, input logic [1:0] r,
                    input logic h, input logic [31:0] pa, input logic [3:0] t);
    @(negedge clk);
    lk_valid = 1'b1;
    lk_sel = s;
    lk_vaddr = va;
    lk_ring = r;
    @(negedge clk);
    lk_valid = 1'b0;
    chk({31'h0, done}, 32'h1);
    chk({31'h0, hit}, {31'h0, h});
    chk({31'h0, miss}, {31'h0, !h});
    chk({31'h0, multi}, {31'h0, exp_multi});
    if (h) begin
      chk(paddr, pa);
      chk({28'h0, attr}, {28'h0, t});
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    chk(icfg, 32'h0);
    chk(dcfg, 32'h0);
    chk(ids, 32'h04030201);
    sreg(2, 32'h0c0b0a55);
    chk(ids, 32'h0c0b0a01);
    lk(0, 32'h00001000, 2'h3, 0, 0, 0);
    lk(1, 32'h00001000, 2'h3, 0, 0, 0);
    $display("test reset done");
  endtask

  task automatic t_fixed;
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 4; i++)
        lk(s[0], va_t[i], 2'h0, 1, pa_t[i], at_t[i]);
    wr(0, 32'hd0000005, 32'h1234502f);
    wr(1, 32'he0000006, 32'h5432102f);
    lk(0, 32'hd0000010, 2'h3, 1, 32'h00000010, 4'h7);
    lk(1, 32'he0000010, 2'h0, 1, 32'hf0000010, 4'h7);
    $display("test fixed done");
  endtask

  task automatic t_ring;
    // Reserved low bits carry a probe-like pattern; they must not matter
    wr(1, 32'h00007ac7, 32'habcde025);
    lk(1, 32'h00007abc, 2'h1, 0, 0, 0);
    lk(1, 32'h00007abc, 2'h2, 1, 32'habcdeabc, 4'h5);
    lk(0, 32'h00007abc, 2'h2, 0, 0, 0);
    // Same page in a second pinned way: both match, last way answers
    wr(1, 32'h00007008, 32'habcde025);
    exp_multi = 1'b1;
    lk(1, 32'h00007abc, 2'h2, 1, 32'habcdeabc, 4'h5);
    exp_multi = 1'b0;
    wr(0, 32'h00009000, 32'h55555007);
    lk(0, 32'h00009abc, 2'h0, 1, 32'h55555abc, 4'h7);
    $display("test ring done");
  endtask

  task automatic t_way4;
    sreg(0, 32'hffffffff);
    chk(icfg, 32'h01130000);
    sreg(1, 32'hfffeffff);
    chk(dcfg, 32'h01120000);
    sreg(0, 32'h00010000);
    chk(icfg, 32'h00010000);
    wr(0, 32'h00400004, 32'h12300007);
    lk(0, 32'h00412345, 2'h0, 1, 32'h12012345, 4'h7);
    $display("test way4 done");
  endtask

  task automatic t_refill;
    int n;
    // Instruction side first, then data side with pinned ways watched
    for (int s = 0; s < 2; s++) begin
      @(negedge clk);
      go = 1'b1;
      rf_in_sel = s[0];
      wr_valid = 1'b1;
      wr_sel = s[0];
      wr_as = 32'hd0000005;
      @(negedge clk);
      go = 1'b0;
      chk({31'h0, rf_ready}, 32'h0);
      repeat (2) @(negedge clk);
      chk({31'h0, rf_valid}, 32'h1);
      wr_valid = 1'b0;
      n = 0;
      while (rf_valid === 1'b1 && n < 10) begin
        @(negedge clk);
        n++;
      end
      chk({31'h0, rf_valid}, 32'h0);
      lk(s[0], 32'h00005abc, 2'h1, 1, 32'hbcdefabc, 4'h3);
      lk(s[0], 32'h00005abc, 2'h0, 0, 0, 0);
    end
    $display("test refill done");
  endtask

  // Ceiling well above the roughly 80 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_fixed();
    t_ring();
    t_way4();
    t_refill();
    complete_run();
  end
endmodule
